// ===== rtl/strap_config_capture.sv
`timescale 1ns/1ps
`include "strap_config_cfg.svh"
// Behaviour
// R1 - strap low: power down after reset
// R2 - sample leader strap on every reset
// R3 - leader strap defaults advertised and forced bits
// R4 - leader bits writable, revert on reset
// R5 - tx strap low: high level enabled
// R6 - tx strap high: high level disabled
// R7 - low-only strap ignores ability writes
// R8 - ability bit reports high level support
// R9 - decode two mac select straps
// R10 - floating straps give documented defaults
// R11 - unmanaged active start runs autonegotiation
// R12 - board holds powerdown strap high unmanaged
// R13 - board drives media strap for converter
// R14 - stay powered down until software clears
// R15 - identifiers readable at both access paths
// R16 - identifier field layout
// R17 - software checks ident then ready bit
// R18 - identifiers invalid until start-up completes
// R19 - powerdown status follows control bit; the status bit reads 0 while ready is low
// R20 - sample after reset, then pins resume
// R21 - powerdown bit loaded, clear leaves powerdown
// R22 - three straps set management address
// R23 - capture once, after STARTUP_CYCLES start-up cycles
// R24 - writes persist until next reset

module strap_config_capture #(
  parameter int          STARTUP_CYCLES = `SCC_STARTUP_CYCLES,
  parameter logic [15:0] ORG_HIGH       = 16'h5a5a, // arbitrary value
  parameter logic [5:0]  ORG_LOW        = 6'h15,    // arbitrary value
  parameter logic [5:0]  MODEL_NUM      = 6'h2a,    // arbitrary value
  parameter logic [3:0]  REV_NUM        = 4'h3      // arbitrary value
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_n_i,
  input  wire strap_config_pkg::strap_pins_t pins_i,
  input  wire strap_config_pkg::strap_pins_t func_i,
  output strap_config_pkg::strap_pins_t     pins_o,
  output strap_config_pkg::strap_pins_t     pins_oe_n_o,
  input  wire strap_config_pkg::mgmt_req_t  mgmt_i,
  output logic                              mgmt_ack_o,
  output logic [15:0]                       mgmt_rdata_o,
  output logic                              system_ready_o,
  output logic                              powerdown_o,
  output logic                              an_enable_o,
  output logic                              adv_leader_o,
  output logic                              forced_leader_o,
  output logic                              high_level_mode_o,
  output logic                              adv_high_level_o,
  output strap_config_pkg::mac_if_t         mac_if_o,
  output logic                              media_converter_o,
  output logic [2:0]                        mgmt_addr_o
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  // ****************************************
  // state
  // ****************************************
  strap_config_pkg::seq_state_t  state_r,  state_nxt;
  logic [CW-1:0]                 cnt_r,    cnt_nxt;
  strap_config_pkg::strap_pins_t strap_r,  strap_nxt;
  logic                          pd_r,     pd_nxt;
  logic                          adv_lead_r, adv_lead_nxt;
  logic                          frc_lead_r, frc_lead_nxt;
  logic                          able_r,   able_nxt;
  logic                          adv_hi_r, adv_hi_nxt;
  logic                          ack_r,    ack_nxt;
  logic [15:0]                   rdata_r,  rdata_nxt;
  strap_config_pkg::strap_pins_t pout_r,   pout_nxt;
  strap_config_pkg::strap_pins_t poe_r,    poe_nxt;
  logic                          ready_r,  ready_nxt;
  logic                          an_r,     an_nxt;

  // ****************************************
  // address decode
  // ****************************************
  logic ident_path;
  logic vend_path;
  logic [15:0] id_high;
  logic [15:0] id_low;
  logic        ident_live;
  logic        wr_ok;
  logic        wr_ctrl;
  logic        wr_lead;
  logic        wr_tx;
  logic        soft_rst;

  always_comb begin
    // clause 22 any, clause 45 on the pma or VEND1 vendor device
    ident_path = !mgmt_i.c45 || (mgmt_i.devad == `SCC_DEVAD_PMA) ||
                 (mgmt_i.devad == `SCC_DEVAD_VEND1); // R15
    vend_path  = mgmt_i.c45 && (mgmt_i.devad == `SCC_DEVAD_VEND2);
    id_high    = ORG_HIGH; // R16
    id_low     = {ORG_LOW, MODEL_NUM, REV_NUM}; // R16
    // identifiers stay hidden until the start-up sequence reports ready
    ident_live = ready_r && (state_r == strap_config_pkg::ST_RUN); // R18
    // writes count only on the VEND2 vendor device once the straps are in
    wr_ok      = mgmt_i.req && mgmt_i.wr && vend_path &&
                 (state_r == strap_config_pkg::ST_RUN);
    wr_ctrl    = wr_ok && (mgmt_i.addr == `SCC_ADDR_CTRL);
    wr_lead    = wr_ok && (mgmt_i.addr == `SCC_ADDR_LEADER);
    wr_tx      = wr_ok && (mgmt_i.addr == `SCC_ADDR_TX_LEVEL);
    soft_rst   = wr_ctrl && mgmt_i.wdata[`SCC_CTRL_SWRST_BIT];
  end

  // ****************************************
  // start-up sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ready_nxt = 1'b0;
    case (state_r)
      strap_config_pkg::ST_RESET: begin
        if (cnt_r == CW'(STARTUP_CYCLES - 1)) begin
          state_nxt = strap_config_pkg::ST_CAPTURE;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      strap_config_pkg::ST_CAPTURE: begin
        state_nxt = strap_config_pkg::ST_RUN;
      end
      strap_config_pkg::ST_RUN: begin
        ready_nxt = 1'b1;
        // software reset reruns the whole strap sequence
        if (soft_rst) begin
          state_nxt = strap_config_pkg::ST_RESET;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = strap_config_pkg::ST_RESET;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= strap_config_pkg::ST_RESET;
      cnt_r   <= '0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ****************************************
  // strap-defaulted registers
  // ****************************************
  always_comb begin
    strap_nxt    = strap_r;
    pd_nxt       = pd_r;
    adv_lead_nxt = adv_lead_r;
    frc_lead_nxt = frc_lead_r;
    able_nxt     = able_r;
    adv_hi_nxt   = adv_hi_r;
    if (state_r == strap_config_pkg::ST_CAPTURE) begin
      strap_nxt    = pins_i; // R23 R20 R2 R22
      pd_nxt       = !pins_i.powerdown_after_reset_strap; // R1 R21 R10
      adv_lead_nxt = pins_i.leader_pref_strap; // R3
      frc_lead_nxt = pins_i.leader_pref_strap; // R3
      able_nxt     = !pins_i.tx_high_level_strap; // R5 R6 R8
      adv_hi_nxt   = !pins_i.tx_high_level_strap;
    end
    if (wr_ctrl) begin
      pd_nxt = mgmt_i.wdata[`SCC_CTRL_PD_BIT]; // R21 R24 R14
    end
    if (wr_lead) begin
      adv_lead_nxt = mgmt_i.wdata[`SCC_LEAD_ADV_BIT]; // R4 R24
      frc_lead_nxt = mgmt_i.wdata[`SCC_LEAD_FORCED_BIT]; // R4
    end
    // the advertised bit only moves while the ability is there
    if (wr_tx && able_r) begin
      adv_hi_nxt = mgmt_i.wdata[`SCC_TX_ADV_BIT]; // R7
    end
    // follows the next powerdown value so it never runs while powered down
    an_nxt = (state_nxt == strap_config_pkg::ST_RUN) && !pd_nxt; // R11 R14
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_r    <= `SCC_STRAP_RESET;
      pd_r       <= 1'b1;
      adv_lead_r <= 1'b0;
      frc_lead_r <= 1'b0;
      able_r     <= 1'b0;
      adv_hi_r   <= 1'b0;
      an_r       <= 1'b0;
    end else begin
      strap_r    <= strap_nxt;
      pd_r       <= pd_nxt;
      adv_lead_r <= adv_lead_nxt;
      frc_lead_r <= frc_lead_nxt;
      able_r     <= able_nxt;
      adv_hi_r   <= adv_hi_nxt;
      an_r       <= an_nxt;
    end
  end

  // ****************************************
  // management response
  // ****************************************
  always_comb begin
    ack_nxt   = 1'b0;
    rdata_nxt = rdata_r;
    if (mgmt_i.req) begin
      ack_nxt   = 1'b1;
      rdata_nxt = `SCC_DATA_RESET;
      if (!mgmt_i.wr) begin
        if (ident_path && mgmt_i.addr == `SCC_ADDR_IDENT_HIGH) begin
          rdata_nxt = ident_live ? id_high : `SCC_DATA_RESET; // R18
        end else if (ident_path && mgmt_i.addr == `SCC_ADDR_IDENT_LOW) begin
          rdata_nxt = ident_live ? id_low : `SCC_DATA_RESET; // R18
        end else if (vend_path) begin
          case (mgmt_i.addr)
            `SCC_ADDR_CTRL: rdata_nxt[`SCC_CTRL_PD_BIT] = pd_r;
            `SCC_ADDR_STATUS: begin
              rdata_nxt[`SCC_STAT_READY_BIT] = ready_r;
              rdata_nxt[`SCC_STAT_PD_BIT]    = pd_r && ready_r; // R19
            end
            `SCC_ADDR_LEADER: begin
              rdata_nxt[`SCC_LEAD_ADV_BIT]    = adv_lead_r;
              rdata_nxt[`SCC_LEAD_FORCED_BIT] = frc_lead_r;
            end
            `SCC_ADDR_TX_LEVEL: begin
              rdata_nxt[`SCC_TX_ABLE_BIT] = able_r; // R8
              rdata_nxt[`SCC_TX_ADV_BIT]  = adv_hi_r;
            end
            `SCC_ADDR_STRAP_VIEW: begin
              rdata_nxt[`SCC_VIEW_MAC_LSB +: 2] = {strap_r.mac_if_select_hi_strap,
                                                   strap_r.mac_if_select_lo_strap};
              rdata_nxt[`SCC_VIEW_MEDIA_BIT]    = strap_r.media_converter_strap;
              rdata_nxt[`SCC_VIEW_ADDR_LSB +: 3] = strap_r.mgmt_addr_strap;
            end
            default: rdata_nxt = `SCC_DATA_RESET;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r   <= 1'b0;
      rdata_r <= `SCC_DATA_RESET;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // shared pin drive
  // ****************************************
  always_comb begin
    // pins released so strap resistors set the level
    pout_nxt = '0;
    poe_nxt  = '1; // R20
    if (state_r == strap_config_pkg::ST_RUN) begin
      pout_nxt = func_i;
      poe_nxt  = '0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pout_r <= '0;
      poe_r  <= '1;
    end else begin
      pout_r <= pout_nxt;
      poe_r  <= poe_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pins_o            = pout_r;
  assign pins_oe_n_o       = poe_r;
  assign mgmt_ack_o        = ack_r;
  assign mgmt_rdata_o      = rdata_r;
  assign system_ready_o    = ready_r;
  assign powerdown_o       = pd_r; // R1
  assign an_enable_o       = an_r;
  assign adv_leader_o      = adv_lead_r;
  assign forced_leader_o   = frc_lead_r;
  assign high_level_mode_o = able_r; // R5 R6
  assign adv_high_level_o  = adv_hi_r;
  // reserved code passes through unchanged
  assign mac_if_o          = strap_config_pkg::mac_if_t'({strap_r.mac_if_select_hi_strap,
                                                          strap_r.mac_if_select_lo_strap}); // R9
  assign media_converter_o = strap_r.media_converter_strap;
  assign mgmt_addr_o       = strap_r.mgmt_addr_strap; // R22

endmodule : strap_config_capture

// ===== shared/strap_config_cfg.svh
`ifndef STRAP_CONFIG_CFG_SVH
`define STRAP_CONFIG_CFG_SVH

// ****************************************
// management addressing
// ****************************************
`define SCC_DEVAD_PMA        5'h01
`define SCC_DEVAD_VEND1      5'h1f
`define SCC_DEVAD_VEND2      5'h1e
`define SCC_ADDR_IDENT_HIGH  16'h0002
`define SCC_ADDR_IDENT_LOW   16'h0003
`define SCC_ADDR_CTRL        16'h0010
`define SCC_ADDR_STATUS      16'h0011
`define SCC_ADDR_LEADER      16'h0012
`define SCC_ADDR_TX_LEVEL    16'h0013
`define SCC_ADDR_STRAP_VIEW  16'h0014

// ****************************************
// field positions
// ****************************************
`define SCC_CTRL_PD_BIT      0
`define SCC_CTRL_SWRST_BIT   1
`define SCC_STAT_READY_BIT   0
`define SCC_STAT_PD_BIT      1
`define SCC_LEAD_ADV_BIT     0
`define SCC_LEAD_FORCED_BIT  1
`define SCC_TX_ABLE_BIT      0
`define SCC_TX_ADV_BIT       1
`define SCC_VIEW_MAC_LSB     0
`define SCC_VIEW_MEDIA_BIT   2
`define SCC_VIEW_ADDR_LSB    3
`define SCC_ID_ORG_LSB       10
`define SCC_ID_MODEL_LSB     4
`define SCC_ID_REV_LSB       0

// ****************************************
// reset values and timing
// ****************************************
`define SCC_STARTUP_CYCLES   16
`define SCC_DATA_RESET       16'h0000
`define SCC_STRAP_RESET      9'h000

`endif

// ===== shared/strap_config_pkg.sv
package strap_config_pkg;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

  typedef enum logic [1:0] {
    MAC_RMII  = 2'b00,
    MAC_RGMII = 2'b01,
    MAC_RESV  = 2'b10,
    MAC_MII   = 2'b11
  } mac_if_t;

  // one bit per shared configuration pin
  typedef struct packed {
    logic [2:0] mgmt_addr_strap;
    logic       media_converter_strap;
    logic       mac_if_select_hi_strap;
    logic       mac_if_select_lo_strap;
    logic       tx_high_level_strap;
    logic       leader_pref_strap;
    logic       powerdown_after_reset_strap;
  } strap_pins_t;

  // decoded management frame
  typedef struct packed {
    logic        req;
    logic        c45;
    logic [4:0]  devad;
    logic [15:0] addr;
    logic        wr;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage : strap_config_pkg

// ===== tb/strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model (
  input  wire strap_config_pkg::strap_pins_t strap_i,
  input  wire strap_config_pkg::strap_pins_t drv_i,
  input  wire strap_config_pkg::strap_pins_t oe_n_i,
  output strap_config_pkg::strap_pins_t      pins_o
);
  // released lines show the resistor level, a floating pin reads low
  assign pins_o = (strap_i & oe_n_i) | (drv_i & ~oe_n_i);
endmodule : strap_board_model

// ===== tb/strap_capture_checker_sva.sv
`timescale 1ns/1ps
module strap_capture_checker (
  input wire logic                          clock_i,
  input wire logic                          rst_n_i,
  input wire strap_config_pkg::mgmt_req_t   mgmt_i,
  input wire logic                          mgmt_ack_o,
  input wire logic [15:0]                   mgmt_rdata_o,
  input wire logic                          system_ready_o,
  input wire logic                          powerdown_o,
  input wire logic                          an_enable_o,
  input wire logic                          high_level_mode_o,
  input wire logic                          adv_high_level_o,
  input wire strap_config_pkg::strap_pins_t func_i,
  input wire strap_config_pkg::strap_pins_t pins_o,
  input wire strap_config_pkg::strap_pins_t pins_oe_n_o,
  input wire strap_config_pkg::mac_if_t     mac_if_o,
  input wire logic [2:0]                    mgmt_addr_o
);
  // ****
  // checks
  // ****
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ack_follows_req_a: assert property (mgmt_i.req |=> mgmt_ack_o) else $error("no ack");
  ack_has_cause_a: assert property (mgmt_ack_o |-> $past(mgmt_i.req)) else $error("stray ack");
  ident_hidden_a: assert property (mgmt_ack_o && !$past(system_ready_o) &&
    ($past(mgmt_i.addr) == 16'h0002 || $past(mgmt_i.addr) == 16'h0003) |->
    mgmt_rdata_o == 16'h0000) else $error("data before ready");
  an_needs_active_a: assert property (an_enable_o |-> !powerdown_o) else $error("an in powerdown");
  adv_needs_able_a: assert property (adv_high_level_o |-> high_level_mode_o) else $error("adv no ability");
  pins_released_a: assert property (!system_ready_o |-> &pins_oe_n_o) else $error("pins driven");
  pins_resume_a: assert property (system_ready_o && $past(system_ready_o) |-> pins_o == $past(func_i))
    else $error("pin function lost");
  straps_held_a: assert property (system_ready_o && $past(system_ready_o) |->
    $stable(mac_if_o) && $stable(mgmt_addr_o) && $stable(high_level_mode_o)) else $error("strap moved");
  cover property (mgmt_ack_o && system_ready_o);
  cover property ($fell(powerdown_o));
  cover property (system_ready_o && !high_level_mode_o);
endmodule : strap_capture_checker

bind strap_config_capture strap_capture_checker chk_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .mgmt_i(mgmt_i), .mgmt_ack_o(mgmt_ack_o), .mgmt_rdata_o(mgmt_rdata_o),
  .system_ready_o(system_ready_o), .powerdown_o(powerdown_o), .an_enable_o(an_enable_o),
  .high_level_mode_o(high_level_mode_o), .adv_high_level_o(adv_high_level_o), .func_i(func_i),
  .pins_o(pins_o), .pins_oe_n_o(pins_oe_n_o), .mac_if_o(mac_if_o), .mgmt_addr_o(mgmt_addr_o));

// ===== tb/tb_strap_config_capture.sv
`timescale 1ns/1ps
module tb_strap_config_capture;
  localparam logic [15:0] ID_HI = 16'h1357; // arbitrary value
  localparam logic [15:0] ID_LO = {6'h0b, 6'h11, 4'h2}; // arbitrary value
  logic clock_i, rst_n_i, ack, rdy, pd, an, adv_l, frc_l, hl, adv_hl, media;
  logic [15:0] rd, got;
  logic [2:0] addr;
  strap_config_pkg::strap_pins_t strap, pins_i, pins_o, oe_n, func;
  strap_config_pkg::mgmt_req_t mg;
  strap_config_pkg::mac_if_t mac;
  int bad_count, n_compared;
  strap_config_capture #(.STARTUP_CYCLES(2), .ORG_HIGH(ID_HI), .ORG_LOW(ID_LO[15:10]),
    .MODEL_NUM(ID_LO[9:4]), .REV_NUM(ID_LO[3:0])) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .pins_i(pins_i), .func_i(func), .pins_o(pins_o), .pins_oe_n_o(oe_n), .mgmt_i(mg),
    .mgmt_ack_o(ack), .mgmt_rdata_o(rd), .system_ready_o(rdy), .powerdown_o(pd),
    .an_enable_o(an), .adv_leader_o(adv_l), .forced_leader_o(frc_l), .high_level_mode_o(hl),
    .adv_high_level_o(adv_hl), .mac_if_o(mac), .media_converter_o(media), .mgmt_addr_o(addr));
  strap_board_model board (.strap_i(strap), .drv_i(pins_o), .oe_n_i(oe_n), .pins_o(pins_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // shared pins carry changing function data once driven after the strap sample
  always @(posedge clock_i) func <= func + 9'h001;
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic start(input logic [8:0] s);
    @(posedge clock_i);
    strap <= s;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
  endtask : start
  task automatic wait_rdy();
    for (int i = 0; i < 40 && rdy !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (rdy !== 1'b1) begin
      chk("ready", 16'h0001, {15'h0, rdy});
      finish_test();
    end
  endtask : wait_rdy
  task automatic xfer(input logic c45, input logic [4:0] dv, input logic [15:0] ad,
                      input logic wr, input logic [15:0] wd);
    @(posedge clock_i);
    mg <= '{1'b1, c45, dv, ad, wr, wd};
    @(posedge clock_i);
    mg.req <= 1'b0;
    #1;
    chk("ack", 16'h0001, {15'h0, ack});
    got = rd;
  endtask : xfer
  // ****
  // scenarios
  // ****
  task automatic t_float();
    start(9'h000);
    wait_rdy();
    chk("pd", 16'h0001, {15'h0, pd});
    chk("able", 16'h0001, {15'h0, hl});
    chk("leader", 16'h0000, {14'h0, adv_l, frc_l});
    chk("mac", 16'h0000, {14'h0, mac});
    chk("addr", 16'h0000, {13'h0, addr});
    chk("adv high", 16'h0001, {15'h0, adv_hl});
    xfer(1'b1, 5'h1e, 16'h0011, 1'b0, 16'h0000);
    chk("status", 16'h0003, got);
    xfer(1'b1, 5'h1e, 16'h0010, 1'b0, 16'h0000);
    chk("ctrl", 16'h0001, got);
    xfer(1'b1, 5'h1e, 16'h0013, 1'b1, 16'h0000);
    chk("adv wr", 16'h0000, {15'h0, adv_hl});
    xfer(1'b1, 5'h1e, 16'h0013, 1'b0, 16'h0000);
    chk("tx able", 16'h0001, got);
    xfer(1'b1, 5'h1e, 16'h0010, 1'b1, 16'h0000);
    @(posedge clock_i);
    #1;
    chk("pd clear", 16'h0001, {15'h0, an & ~pd});
    $display("test float done");
  endtask : t_float
  task automatic t_high();
    start(9'h1ff);
    wait_rdy();
    @(posedge clock_i);
    #1;
    chk("active", 16'h0001, {15'h0, an & ~pd});
    chk("leader", 16'h0003, {14'h0, adv_l, frc_l});
    chk("able", 16'h0000, {15'h0, hl});
    chk("media", 16'h0001, {15'h0, media});
    chk("adv high", 16'h0000, {15'h0, adv_hl});
    chk("pins oe", 16'h0000, {7'h0, oe_n});
    xfer(1'b1, 5'h1e, 16'h0014, 1'b0, 16'h0000);
    chk("view", 16'h003f, got);
    xfer(1'b1, 5'h1e, 16'h0013, 1'b1, 16'h0002);
    xfer(1'b1, 5'h1e, 16'h0013, 1'b0, 16'h0000);
    chk("tx reg", 16'h0000, got);
    $display("test high done");
  endtask : t_high
  task automatic t_leader();
    start(9'h000);
    wait_rdy();
    xfer(1'b1, 5'h1e, 16'h0012, 1'b1, 16'h0003);
    chk("leader wr", 16'h0003, {14'h0, adv_l, frc_l});
    xfer(1'b1, 5'h1e, 16'h0012, 1'b0, 16'h0000);
    chk("leader rd", 16'h0003, got);
    xfer(1'b1, 5'h1e, 16'h0010, 1'b1, 16'h0002);
    repeat (2) @(posedge clock_i);
    wait_rdy();
    chk("leader rst", 16'h0000, {14'h0, adv_l, frc_l});
    $display("test leader done");
  endtask : t_leader
  task automatic t_mac();
    for (int m = 0; m < 4; m++) begin
      start(9'(m << 3));
      wait_rdy();
      chk("mac", 16'(m), {14'h0, mac});
    end
    $display("test mac done");
  endtask : t_mac
  task automatic t_ident();
    start(9'h000);
    xfer(1'b0, 5'h00, 16'h0002, 1'b0, 16'h0000);
    chk("early id", 16'h0000, got);
    wait_rdy();
    xfer(1'b0, 5'h00, 16'h0002, 1'b0, 16'h0000);
    chk("c22 id", ID_HI, got);
    xfer(1'b1, 5'h01, 16'h0003, 1'b0, 16'h0000);
    chk("c45 id", ID_LO, got);
    xfer(1'b1, 5'h1f, 16'h0002, 1'b0, 16'h0000);
    chk("vend id", ID_HI, got);
    xfer(1'b1, 5'h1e, 16'h0020, 1'b0, 16'h0000);
    chk("unmapped", 16'h0000, got);
    xfer(1'b1, 5'h1e, 16'h0011, 1'b0, 16'h0000);
    chk("ready after id", 16'h0003, got);
    $display("test ident done");
  endtask : t_ident
  initial begin
    rst_n_i = 1'b0;
    strap = '0;
    mg = '0;
    func = 9'h0a5;
    bad_count = 0;
    n_compared = 0;
    t_float();
    t_high();
    t_leader();
    t_mac();
    t_ident();
    finish_test();
  end
endmodule : tb_strap_config_capture
